/* File: inc/tc_pkg.sv */
// Constants for the eight-bit timer / event counter / capture unit.
// Assumes a single system clock and a plain strobe register port.

package tc_pkg;

  // ----------------------------------------------------------------
  // Register map (word index on the 2-bit address port)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 2;
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_PERIOD_A = 2'h1;
  localparam logic [1:0] ADDR_CAPTURE_B = 2'h2;
  localparam logic [1:0] ADDR_COUNT = 2'h3;

  // ----------------------------------------------------------------
  // counter_control_reg fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned CTRL_SRC_LSB = 1;
  localparam int unsigned CTRL_SRC_MSB = 3;
  localparam int unsigned CTRL_RUN_BIT = 4;
  localparam int unsigned CTRL_AUTO_CAPTURE_ENABLE_BIT = 6;
  // Bits 5 and 7 are not stored and read as zero
  localparam logic [7:0] CTRL_WMASK = 8'h5f;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Source code that selects the pin instead of the prescaler when the mode bit is clear
  localparam logic [2:0] SRC_EXTERNAL = 3'h7;

  // ----------------------------------------------------------------
  // Prescaler: code 000 divides by 2^13, each step halves that,
  // the half-rate select adds one more stage
  // ----------------------------------------------------------------
  localparam int unsigned PRE_W = 15;
  localparam logic [3:0] PRE_SHIFT_BASE = 4'hd;
  localparam logic [PRE_W-1:0] PRE_ONE = 15'h0001;
  localparam logic [PRE_W-1:0] PRE_ZERO = 15'h0000;

  // ----------------------------------------------------------------
  // Data values
  // ----------------------------------------------------------------
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] PERIOD_A_RESET = 8'hff;
  localparam logic [7:0] CAPTURE_B_RESET = 8'hff;

  // ----------------------------------------------------------------
  // Operating state of the counter
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_TIMER = 2'b01,
    OP_EVENT = 2'b10,
    OP_CAPTURE = 2'b11
  } op_e;

endpackage

/* File: hdl/timer_capture_counter.sv */
// Eight-bit up-counter with timer, event counter and capture modes.
// Assumes registers are reached over a strobe port on mclk_i and that
// the pulse source keeps every phase at least four clocks long.
//
// What this block does
// - Three modes: periodic timer, external event counting, pulse capture.
// - Timer mode counts ticks of the selected prescaled internal clock.
// - Timer match with period_capture_a pulses tc_irq and clears counter.
// - Auto-capture copies the live count into capture_b continuously.
// - The zero loaded after a match is not copied into capture_b.
// - Event mode counts rising edges of the event input pin.
// - Event match is acted on at the following falling pin edge.
// - Auto-capture also works in event counter mode.
// - Capture mode counts the selected internal prescaled clock.
// - Capture mode falling edge latches the count into capture_b.
// - Capture rising edge latches period_capture_a, interrupts, clears counter.
// - Rising first edge leaves capture_b at its last value, all ones at reset.
// - Capture overflow interrupts, loads all ones into period_capture_a, clears.
// - After overflow, capture and overflow wait for a period_capture_a read.
// - Run bit low stops and clears the counter; high starts it.
// - STOP mode entry clears the run bit and halts the counter.
// - Source code 111 with the mode bit clear selects the pin, giving event counter behaviour.
// - Auto-capture works in timer and event modes only.

`timescale 1ns/100ps

module timer_capture_counter
  import tc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // System controls
  input wire logic prescale_half_select_i,
  input wire logic stop_mode_entry_i,
  // External pulse input
  input wire logic event_input_pin_i,
  // Interrupt request
  output logic tc_irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] period_a;
    logic [7:0] capture_b;
    logic [7:0] count;
    logic [PRE_W-1:0] pre;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic just_cleared;
    logic capture_hold;
    logic irq;
    logic [7:0] rdata;
  } state_s;

  localparam state_s STATE_RESET = '{
    ctrl: CTRL_RESET,
    period_a: PERIOD_A_RESET,
    capture_b: CAPTURE_B_RESET,
    count: COUNT_ZERO,
    pre: PRE_ZERO,
    pin_meta: 1'b0,
    pin_sync: 1'b0,
    pin_prev: 1'b0,
    just_cleared: 1'b0,
    capture_hold: 1'b0,
    irq: 1'b0,
    rdata: COUNT_ZERO
  };

  state_s r;
  state_s next_r;

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  logic run;
  logic capture_mode;
  logic auto_capture_enable;
  logic [2:0] source_select;
  logic pin_rise;
  logic pin_fall;
  logic [3:0] pre_shift;
  logic [PRE_W-1:0] pre_mask;
  logic tick;
  op_e op;

  assign run = r.ctrl[CTRL_RUN_BIT];
  assign capture_mode = r.ctrl[CTRL_MODE_BIT];
  assign auto_capture_enable = r.ctrl[CTRL_AUTO_CAPTURE_ENABLE_BIT];
  assign source_select = r.ctrl[CTRL_SRC_MSB:CTRL_SRC_LSB];

  // Edges come from the second and third samples only
  assign pin_rise = r.pin_sync & ~r.pin_prev;
  assign pin_fall = ~r.pin_sync & r.pin_prev;

  // A tick is one clock per full wrap of the selected prescaler stages
  assign pre_shift = PRE_SHIFT_BASE - {1'b0, source_select}
                     + {3'h0, prescale_half_select_i};
  assign pre_mask = (PRE_ONE << pre_shift) - PRE_ONE;
  assign tick = ((r.pre & pre_mask) == pre_mask);

  always_comb begin
    if (!run) begin
      op = OP_IDLE;
    end else if (capture_mode) begin
      op = OP_CAPTURE;
    end else if (source_select == SRC_EXTERNAL) begin
      op = OP_EVENT;
    end else begin
      op = OP_TIMER;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.irq = 1'b0;

    // Two-stage synchroniser plus one history sample
    next_r.pin_meta = event_input_pin_i;
    next_r.pin_sync = r.pin_meta;
    next_r.pin_prev = r.pin_sync;

    // Prescaler restarts with each start so the first period is whole
    if (run) begin
      next_r.pre = r.pre + PRE_ONE;
    end else begin
      next_r.pre = PRE_ZERO;
    end

    // Software writes; hardware updates below take precedence
    if (wr_i) begin
      case (addr_i)
        ADDR_CTRL: begin
          next_r.ctrl = wdata_i & CTRL_WMASK;
        end
        ADDR_PERIOD_A: begin
          next_r.period_a = wdata_i;
        end
        default: begin
        end
      endcase
    end

    // Reading the period register releases a suspended capture
    if (rd_i && (addr_i == ADDR_PERIOD_A)) begin
      next_r.capture_hold = 1'b0;
    end

    case (op)
      OP_IDLE: begin
        // Stopped: counter held at zero
        next_r.count = COUNT_ZERO;
        next_r.just_cleared = 1'b0;
        next_r.capture_hold = 1'b0;
      end

      OP_TIMER: begin
        if (tick) begin
          if (r.count == r.period_a) begin
            next_r.count = COUNT_ZERO;
            next_r.irq = 1'b1;
            next_r.just_cleared = 1'b1;
          end else begin
            next_r.count = r.count + COUNT_ONE;
            next_r.just_cleared = 1'b0;
          end
        end
      end

      OP_EVENT: begin
        // Phases are at least four clocks, so rise and fall never coincide
        if (pin_rise) begin
          next_r.count = r.count + COUNT_ONE;
          next_r.just_cleared = 1'b0;
        end else if (pin_fall && (r.count == r.period_a)) begin
          next_r.count = COUNT_ZERO;
          next_r.irq = 1'b1;
          next_r.just_cleared = 1'b1;
        end
      end

      OP_CAPTURE: begin
        next_r.just_cleared = 1'b0;
        if (tick) begin
          next_r.count = r.count + COUNT_ONE;
        end
        if (!r.capture_hold) begin
          if (pin_rise) begin
            // Only the period register moves; capture_b keeps its value
            next_r.period_a = r.count;
            next_r.irq = 1'b1;
            next_r.count = COUNT_ZERO;
          end else if (pin_fall) begin
            next_r.capture_b = r.count;
          end else if (tick && (r.count == COUNT_MAX)) begin
            next_r.period_a = COUNT_MAX;
            next_r.irq = 1'b1;
            next_r.count = COUNT_ZERO;
            next_r.capture_hold = 1'b1;
          end
        end
      end

      default: begin
        next_r.count = COUNT_ZERO;
      end
    endcase

    // Live copy lags the counter by one clock; the zero after a match
    // is skipped so software still sees the count that matched
    if (auto_capture_enable && ((op == OP_TIMER) || (op == OP_EVENT))) begin
      if (!r.just_cleared) begin
        next_r.capture_b = r.count;
      end
    end

    // STOP entry beats a same-cycle software start
    if (stop_mode_entry_i) begin
      next_r.ctrl[CTRL_RUN_BIT] = 1'b0;
    end

    // Read data for the cycle after the strobe
    next_r.rdata = COUNT_ZERO;
    if (rd_i) begin
      case (addr_i)
        ADDR_CTRL: begin
          next_r.rdata = r.ctrl & CTRL_WMASK;
        end
        ADDR_PERIOD_A: begin
          next_r.rdata = r.period_a;
        end
        ADDR_CAPTURE_B: begin
          next_r.rdata = r.capture_b;
        end
        ADDR_COUNT: begin
          next_r.rdata = r.count;
        end
        default: begin
          next_r.rdata = COUNT_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= STATE_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = r.rdata;
  assign tc_irq_o = r.irq;

endmodule

/* File: tb/pulse_source.sv */
// Behavioural pulse source on the counter input pin.
// Assumes start_i is raised for one clock while busy_o is low.
`timescale 1ns/100ps
module pulse_source (
  // Clock and command
  input wire logic mclk_i,
  input wire logic start_i,
  input wire logic [7:0] n_i,
  input wire logic [15:0] phase_i,
  // Pin and status
  output logic pin_o,
  output logic busy_o
);
  initial begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge mclk_i);
      if (start_i) begin
        busy_o <= 1'b1;
        repeat (n_i) begin
          pin_o <= 1'b1;
          // Never under four clocks, else the synchroniser may miss it
          repeat (phase_i < 4 ? 4 : phase_i) @(posedge mclk_i);
          pin_o <= 1'b0;
          repeat (phase_i < 4 ? 4 : phase_i) @(posedge mclk_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule

/* File: tb/tc_monitor.sv */
// Port checker for the timer/capture counter.
// Assumes ctrl changes only through the register port and STOP mode entry.
`timescale 1ns/100ps
module tc_monitor
  import tc_pkg::*;
(
  // Watched ports
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic stop_mode_entry_i,
  input wire logic event_input_pin_i,
  input wire logic tc_irq_o
);
  logic [7:0] ctl;
  logic ev;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Shadow of ctrl; a stop in the same cycle beats a run write
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl <= CTRL_RESET;
    end else if (wr_i && addr_i == ADDR_CTRL) begin
      ctl <= wdata_i & CTRL_WMASK & {3'h7, !stop_mode_entry_i, 4'hf};
    end else if (stop_mode_entry_i) begin
      ctl[CTRL_RUN_BIT] <= 1'b0;
    end
  end
  assign ev = ctl[4] && !ctl[0] && ctl[3:1] == SRC_EXTERNAL;
  ctrl_read_a: assert property (rd_i && addr_i == ADDR_CTRL |=> rdata_o == $past(ctl))
    else $error("ctrl readback wrong");
  stop_quiet_a: assert property (!ctl[4] && !$past(ctl[4]) && !$past(ctl[4], 2) |-> !tc_irq_o)
    else $error("irq while stopped");
  irq_pulse_a: assert property (tc_irq_o |=> !tc_irq_o)
    else $error("irq longer than one cycle");
  irq_spacing_a: assert property (!ctl[0] && tc_irq_o |=> !tc_irq_o [*7])
    else $error("irq too soon after match");
  event_fall_a: assert property (ev && tc_irq_o |-> !$past(event_input_pin_i, 3))
    else $error("event irq not after falling edge");
  event_idle_a: assert property ((ev && $stable(event_input_pin_i)) [*8] |-> !tc_irq_o)
    else $error("event irq without pin activity");
  read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read cycle");
  reset_quiet_a: assert property (!$past(rst_n_i) |-> !tc_irq_o)
    else $error("irq right after reset");
  cover property (ev && tc_irq_o);
  cover property (ctl[0] && tc_irq_o);
  cover property (rd_i && addr_i == ADDR_PERIOD_A);
endmodule

bind timer_capture_counter tc_monitor mon (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .stop_mode_entry_i, .event_input_pin_i, .tc_irq_o);

/* File: tb/timer_capture_counter_tb.sv */
// Self-checking bench for the timer/capture counter.
// Assumes the pulse source model drives the input pin.
`timescale 1ns/100ps
module timer_capture_counter_tb;
  import tc_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic prescale_half_select_i = 1'b0;
  logic stop_mode_entry_i = 1'b0;
  logic go = 1'b0;
  logic [7:0] n_pulse = 8'h01;
  logic [15:0] phase = 16'h0004;
  logic event_input_pin_i;
  logic busy;
  logic [7:0] rdata_o;
  logic tc_irq_o;
  logic [15:0] rows [3] = '{16'hef4f, 16'ha000, 16'h0f0f};
  int n_mismatch = 0;
  int checked = 0;
  int n_irq = 0;
  int k;
  realtime t0;
  always #5 mclk_i = ~mclk_i;
  always @(negedge mclk_i) if (tc_irq_o === 1'b1) n_irq++;
  timer_capture_counter uut (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .prescale_half_select_i, .stop_mode_entry_i, .event_input_pin_i, .tc_irq_o);
  pulse_source src (.mclk_i, .start_i(go), .n_i(n_pulse), .phase_i(phase),
    .pin_o(event_input_pin_i), .busy_o(busy));
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic s = 1'b0);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    stop_mode_entry_i <= s;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    stop_mode_entry_i <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic pulse(input logic [7:0] n, input logic [15:0] ph);
    n_pulse <= n;
    phase <= ph;
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    @(posedge mclk_i);
    while (busy) @(posedge mclk_i);
  endtask
  task automatic wait_irq(input int n);
    int c;
    c = 0;
    while (n_irq < n && c < 40000) begin
      @(posedge mclk_i);
      c++;
    end
    // A wait that runs out is a failure in its own right
    if (n_irq < n) begin
      $display("mismatch at %0t: got %h expected %h", $time, n_irq, n);
      n_mismatch++;
    end
  endtask
  // Clocks between two matches, with the prescaler already settled
  task automatic period(input int exp);
    wait_irq(n_irq + 1);
    t0 = $realtime;
    wait_irq(n_irq + 1);
    chk(16'(int'(($realtime - t0) / 10)), 16'(exp));
  endtask
  task automatic reset;
    rst_n_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    reset;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_CAPTURE_B, CAPTURE_B_RESET);
    wr(ADDR_CAPTURE_B, 8'h12);
    rd(ADDR_CAPTURE_B, 8'hff);
    foreach (rows[i]) begin
      wr(ADDR_CTRL, rows[i][15:8]);
      rd(ADDR_CTRL, rows[i][7:0]);
    end
    $display("register test done");
    wr(ADDR_PERIOD_A, 8'h02);
    wr(ADDR_CTRL, 8'h5e);
    pulse(2, 4);
    repeat (6) @(posedge mclk_i);
    chk(16'(n_irq), 16'h0001);
    rd(ADDR_COUNT, 8'h00);
    rd(ADDR_CAPTURE_B, 8'h02);
    pulse(1, 4);
    rd(ADDR_COUNT, 8'h01);
    rd(ADDR_CAPTURE_B, 8'h01);
    wr(ADDR_COUNT, 8'h00, 1'b1);
    rd(ADDR_CTRL, 8'h4e);
    rd(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL, 8'h5c, 1'b1);
    rd(ADDR_CTRL, 8'h4c);
    $display("event test done");
    wr(ADDR_CTRL, 8'h5c);
    period(384);
    rd(ADDR_CAPTURE_B, 8'h02);
    repeat (140) @(posedge mclk_i);
    rd(ADDR_CAPTURE_B, 8'h01);
    prescale_half_select_i <= 1'b1;
    period(768);
    wr(ADDR_CTRL, 8'h4c);
    rd(ADDR_COUNT, 8'h00);
    $display("timer test done");
    prescale_half_select_i <= 1'b0;
    reset;
    k = n_irq;
    wr(ADDR_CTRL, 8'h5d);
    fork
      pulse(2, 280);
      begin
        repeat (30) @(posedge mclk_i);
        rd(ADDR_PERIOD_A, 8'h00);
        rd(ADDR_CAPTURE_B, 8'hff);
      end
    join
    rd(ADDR_CAPTURE_B, 8'h02);
    rd(ADDR_PERIOD_A, 8'h04);
    chk(16'(n_irq - k), 16'h0002);
    wait_irq(k + 3);
    rd(ADDR_CAPTURE_B, 8'h02);
    pulse(1, 8);
    chk(16'(n_irq - k), 16'h0003);
    rd(ADDR_CAPTURE_B, 8'h02);
    rd(ADDR_PERIOD_A, 8'hff);
    pulse(1, 8);
    chk(16'(n_irq - k), 16'h0004);
    $display("capture test done");
    test_done;
  end
  initial begin
    repeat (60000) @(posedge mclk_i);
    n_mismatch++;
    test_done;
  end
endmodule
